// ===== aiw_pkg.sv
// shared constants for the analog i/o word interface
package aiw_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int CONV_SLOW_US = 1000;
  localparam int CONV_FAST_US = 500;
  localparam int CONV_SLOW_CYC = CLK_HZ / 1_000_000 * CONV_SLOW_US;
  localparam int STRAP_WAIT   = 2;

  // ---------------------------------------------------------------
  // word allocation
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_BASE   = 16'h07d0;
  localparam logic [15:0] IO_STEP   = 16'h000a;
  localparam logic [15:0] IO_WORDS  = 16'h000a;
  localparam logic [15:0] PRM_BASE  = 16'h4e20;
  localparam logic [15:0] PRM_STEP  = 16'h0064;
  localparam logic [15:0] PRM_WORDS = 16'h0064;

  localparam logic [3:0] IO_CTRL  = 4'h0;
  localparam logic [3:0] IO_SET1  = 4'h1;
  localparam logic [3:0] IO_SET2  = 4'h2;
  localparam logic [3:0] IO_CONV1 = 4'h5;
  localparam logic [3:0] IO_CONV4 = 4'h8;
  localparam logic [3:0] IO_FLAGS = 4'h9;

  localparam logic [6:0] PRM_MODE  = 7'h00;
  localparam logic [6:0] PRM_RANGE = 7'h01;
  localparam logic [6:0] PRM_HOLD  = 7'h02;
  localparam logic [6:0] PRM_TIME  = 7'h12;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN0    = 0;
  localparam int CTRL_PEAK0  = 4;
  localparam int FLAG_DISC0  = 4;
  localparam int FLAG_ADJ    = 13;
  localparam int FLAG_SETERR = 14;
  localparam int RANGE_IN0   = 4;
  localparam int MODE_ADJ    = 0;
  localparam int TIME_FAST   = 0;

  localparam logic [1:0] RNG_1_5V  = 2'h0;
  localparam logic [1:0] RNG_0_10V = 2'h1;
  localparam logic [1:0] RNG_0_5V  = 2'h2;
  localparam logic [1:0] RNG_BIP   = 2'h3;

  localparam logic [1:0] HOLD_CLEAR_CHOICE = 2'h0;
  localparam logic [1:0] HOLD_KEEP         = 2'h1;
  localparam logic [1:0] HOLD_MAX          = 2'h2;

  localparam logic [15:0] UNI_MAX_4K = 16'h0fa0;
  localparam logic [15:0] UNI_MAX_8K = 16'h1f40;
  localparam logic [15:0] BIP_MAX_4K = 16'h0898;
  localparam logic [15:0] BIP_MIN_4K = 16'hf768;
  localparam logic [15:0] BIP_MAX_8K = 16'h1130;
  localparam logic [15:0] BIP_MIN_8K = 16'heed0;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  // ---------------------------------------------------------------
  // host controller registers (ahb byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] H_CTRL  = 8'h00;
  localparam logic [7:0] H_ADDR  = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_GO    = 8'h0c;
  localparam logic [7:0] H_RDATA = 8'h10;
  localparam logic [7:0] H_STAT  = 8'h14;
  localparam logic [7:0] H_MASK  = 8'h18;
  localparam logic [7:0] H_STATE = 8'h1c;

  localparam int HC_TABLES  = 0;
  localparam int HC_STANDBY = 1;
  localparam int HC_FATAL   = 2;
  localparam int GO_START   = 0;
  localparam int GO_WRITE   = 1;
  localparam int GO_RESTART = 2;
  localparam int ST_DONE    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_RESTART = 2;
  localparam int ST_BITS    = 3;

  typedef enum logic {AIW_IDLE, AIW_BUSY} aiw_hstate_t;

endpackage : aiw_pkg

// ===== aiw_link_if.sv
// word exchange link between host cpu end and analog unit end
`timescale 1ns/1ps
interface aiw_link_if (
  input wire logic clk
);
  logic        req;
  logic        wr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        restart;
  logic        standby;
  logic        fatal;
  logic        ack;
  logic [15:0] rdata;

  modport dev  (input req, wr, addr, wdata, restart, standby, fatal, output ack, rdata);
  modport host (output req, wr, addr, wdata, restart, standby, fatal, input ack, rdata);
endinterface : aiw_link_if

// ===== aiw_device.sv
// analog unit end: word map, clamping, output hold, conversion sampling
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps

// Notes on behaviour
// - out-of-range set values saturate at limits
// - bipolar range uses two's complement words
// - parameters take effect only after restart
// - adjustment mode entered and left via restart
// - unit one occupies 2010-2019 and 20100-20199
// - input conversions at base plus five..eight
// - output set values at base plus one, two
// - disconnection flags in bits 4-7, word nine
// - unipolar conversions span 0000 to 0FA0, or 0000 to 1F40 at 8000 resolution
// - host exchanges everything through allocated words
// - host builds io tables before exchanging
// - stopped outputs follow hold choice
// - parameter selects 8000 resolution, 500 us
module aiw_device #(
  parameter int CONV_SLOW_CYC = aiw_pkg::CONV_SLOW_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // link to host
  aiw_link_if.dev          link,
  // unit number switch
  input  wire logic [6:0]  unit_no,
  // converter front end, four inputs of 16 bits
  input  wire logic [63:0] adc_raw,
  input  wire logic [3:0]  disc_raw,
  // converter back end
  output logic      [31:0] dac_word,
  output logic      [1:0]  dac_live,
  output logic             adj_mode
);
  localparam int CONV_FAST_CYC = CONV_SLOW_CYC * aiw_pkg::CONV_FAST_US / aiw_pkg::CONV_SLOW_US;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0]  unit_s1_q, unit_s2_q;
  logic [63:0] adc_s1_q, adc_s2_q;
  logic [3:0]  disc_s1_q, disc_s2_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      unit_s1_q <= '0;
      unit_s2_q <= '0;
      adc_s1_q  <= '0;
      adc_s2_q  <= '0;
      disc_s1_q <= '0;
      disc_s2_q <= '0;
    end
    else
    begin
      unit_s1_q <= unit_no;
      unit_s2_q <= unit_s1_q;
      adc_s1_q  <= adc_raw;
      adc_s2_q  <= adc_s1_q;
      disc_s1_q <= disc_raw;
      disc_s2_q <= disc_s1_q;
    end

  // ---------------------------------------------------------------
  // unit number, caught once after reset release
  // ---------------------------------------------------------------
  logic [6:0] unit_q;
  logic [1:0] strap_cnt_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      unit_q      <= '0;
      strap_cnt_q <= '0;
    end
    else if (strap_cnt_q == 2'(aiw_pkg::STRAP_WAIT))
    begin
      unit_q      <= unit_s2_q;
      strap_cnt_q <= strap_cnt_q + 2'd1;
    end
    else if (strap_cnt_q < 2'(aiw_pkg::STRAP_WAIT))
      strap_cnt_q <= strap_cnt_q + 2'd1;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [15:0] io_base, prm_base, io_off, prm_off;
  logic        io_hit, prm_hit, take;

  assign io_base  = aiw_pkg::IO_BASE + 16'(unit_q) * aiw_pkg::IO_STEP;
  assign prm_base = aiw_pkg::PRM_BASE + 16'(unit_q) * aiw_pkg::PRM_STEP;
  assign io_off   = link.addr - io_base;
  assign prm_off  = link.addr - prm_base;
  assign io_hit   = (link.addr >= io_base) && (io_off < aiw_pkg::IO_WORDS);
  assign prm_hit  = (link.addr >= prm_base) && (prm_off < aiw_pkg::PRM_WORDS);
  assign take     = link.req && !link.ack;

  // ---------------------------------------------------------------
  // written words: io control, set values, parameter area
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q, set1_q, set2_q;
  logic [15:0] prm_mode_q, prm_range_q, prm_hold_q, prm_time_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ctrl_q      <= '0;
      set1_q      <= '0;
      set2_q      <= '0;
      prm_mode_q  <= '0;
      prm_range_q <= '0;
      prm_hold_q  <= '0;
      prm_time_q  <= '0;
    end
    else if (take && link.wr)
    begin
      if (io_hit)
        unique case (io_off[3:0])
          aiw_pkg::IO_CTRL: ctrl_q <= link.wdata;
          aiw_pkg::IO_SET1: set1_q <= link.wdata;
          aiw_pkg::IO_SET2: set2_q <= link.wdata;
          default: ;
        endcase
      else if (prm_hit)
        unique case (prm_off[6:0])
          aiw_pkg::PRM_MODE:  prm_mode_q  <= link.wdata;
          aiw_pkg::PRM_RANGE: prm_range_q <= link.wdata;
          aiw_pkg::PRM_HOLD:  prm_hold_q  <= link.wdata;
          aiw_pkg::PRM_TIME:  prm_time_q  <= link.wdata;
          default: ;
        endcase
    end

  // ---------------------------------------------------------------
  // active configuration, loaded only by restart or reset
  // ---------------------------------------------------------------
  logic [15:0] cfg_range_q, cfg_hold_q;
  logic        cfg_adj_q, cfg_fast_q, set_err;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      cfg_range_q <= '0;
      cfg_hold_q  <= '0;
      cfg_adj_q   <= 1'b0;
      cfg_fast_q  <= 1'b0;
    end
    else if (link.restart)
    begin
      cfg_range_q <= prm_range_q;
      cfg_hold_q  <= prm_hold_q;
      cfg_adj_q   <= prm_mode_q[aiw_pkg::MODE_ADJ];
      cfg_fast_q  <= prm_time_q[aiw_pkg::TIME_FAST];
    end

  assign set_err  = (cfg_hold_q[1:0] == 2'h3) || (cfg_hold_q[3:2] == 2'h3);
  assign adj_mode = cfg_adj_q;

  // ---------------------------------------------------------------
  // range limits and clamping
  // ---------------------------------------------------------------
  function automatic logic [15:0] aiw_hi(input logic [1:0] rng, input logic hres);
    if (rng == aiw_pkg::RNG_BIP)
      return hres ? aiw_pkg::BIP_MAX_8K : aiw_pkg::BIP_MAX_4K;
    return hres ? aiw_pkg::UNI_MAX_8K : aiw_pkg::UNI_MAX_4K;
  endfunction : aiw_hi

  function automatic logic [15:0] aiw_lo(input logic [1:0] rng, input logic hres);
    if (rng == aiw_pkg::RNG_BIP)
      return hres ? aiw_pkg::BIP_MIN_8K : aiw_pkg::BIP_MIN_4K;
    return aiw_pkg::WORD_ZERO;
  endfunction : aiw_lo

  function automatic logic [15:0] aiw_clamp(input logic [15:0] v, input logic [1:0] rng, input logic hres);
    logic [15:0] hi;
    logic [15:0] lo;
    hi = aiw_hi(rng, hres);
    lo = aiw_lo(rng, hres);
    if ($signed(v) > $signed(hi))
      return hi;
    if ($signed(v) < $signed(lo))
      return lo;
    return v;
  endfunction : aiw_clamp

  // ---------------------------------------------------------------
  // conversion period tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_lim;
  logic        tick;

  assign tick_lim = cfg_fast_q ? 32'(CONV_FAST_CYC - 1) : 32'(CONV_SLOW_CYC - 1);
  assign tick     = (tick_cnt_q >= tick_lim);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 32'd1;

  // ---------------------------------------------------------------
  // input conversion values, with peak hold
  // ---------------------------------------------------------------
  logic [15:0] conv_q [4];
  logic [3:0]  disc_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
        conv_q[i] <= '0;
      disc_q <= '0;
    end
    else if (tick && !cfg_adj_q)
    begin
      disc_q <= disc_s2_q;
      for (int i = 0; i < 4; i++)
      begin
        logic [15:0] v;
        v = aiw_clamp(adc_s2_q[16*i +: 16], cfg_range_q[aiw_pkg::RANGE_IN0 + 2*i +: 2], cfg_fast_q);
        if (!ctrl_q[aiw_pkg::CTRL_PEAK0 + i] || ($signed(v) > $signed(conv_q[i])))
          conv_q[i] <= v;
      end
    end

  // ---------------------------------------------------------------
  // analog outputs and hold choice
  // ---------------------------------------------------------------
  logic [15:0] set_w [2];
  logic        run [2];

  assign set_w[0] = set1_q;
  assign set_w[1] = set2_q;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      dac_word <= '0;
    else if (tick)
      for (int c = 0; c < 2; c++)
        if (run[c])
          dac_word[16*c +: 16] <= aiw_clamp(set_w[c], cfg_range_q[2*c +: 2], cfg_fast_q);
        else
          unique case (cfg_hold_q[2*c +: 2])
            aiw_pkg::HOLD_CLEAR_CHOICE: dac_word[16*c +: 16] <= aiw_pkg::WORD_ZERO;
            aiw_pkg::HOLD_KEEP:         dac_word[16*c +: 16] <= dac_word[16*c +: 16];
            aiw_pkg::HOLD_MAX:          dac_word[16*c +: 16] <= aiw_hi(cfg_range_q[2*c +: 2], cfg_fast_q);
            default:                    dac_word[16*c +: 16] <= aiw_pkg::WORD_ZERO;
          endcase

  always_comb
    for (int c = 0; c < 2; c++)
      run[c] = ctrl_q[aiw_pkg::CTRL_EN0 + c] && !link.standby && !link.fatal && !set_err && !cfg_adj_q;

  assign dac_live = {run[1], run[0]};

  // ---------------------------------------------------------------
  // read answers, one cycle after the request is taken
  // ---------------------------------------------------------------
  logic [15:0] flags_w, rd_d;
  logic [15:0] rdata_q;
  logic        ack_q;

  always_comb
  begin
    flags_w = '0;
    flags_w[aiw_pkg::FLAG_DISC0 +: 4] = disc_q;
    flags_w[aiw_pkg::FLAG_ADJ]        = cfg_adj_q;
    flags_w[aiw_pkg::FLAG_SETERR]     = set_err;
    rd_d = '0;
    if (io_hit)
    begin
      if (io_off[3:0] >= aiw_pkg::IO_CONV1 && io_off[3:0] <= aiw_pkg::IO_CONV4)
        rd_d = conv_q[2'(io_off[3:0] - aiw_pkg::IO_CONV1)];
      else
        unique case (io_off[3:0])
          aiw_pkg::IO_CTRL:  rd_d = ctrl_q;
          aiw_pkg::IO_SET1:  rd_d = set1_q;
          aiw_pkg::IO_SET2:  rd_d = set2_q;
          aiw_pkg::IO_FLAGS: rd_d = flags_w;
          default:           rd_d = '0;
        endcase
    end
    else if (prm_hit)
      unique case (prm_off[6:0])
        aiw_pkg::PRM_MODE:  rd_d = prm_mode_q;
        aiw_pkg::PRM_RANGE: rd_d = prm_range_q;
        aiw_pkg::PRM_HOLD:  rd_d = prm_hold_q;
        aiw_pkg::PRM_TIME:  rd_d = prm_time_q;
        default:            rd_d = '0;
      endcase
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= take;
      if (take && !link.wr)
        rdata_q <= rd_d;
    end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

endmodule : aiw_device

// ===== aiw_host.sv
// host cpu end: ahb-lite register set driving word exchange over the link
`timescale 1ns/1ps
module aiw_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // interrupt
  output logic             irq,
  // link to unit
  aiw_link_if.host         link
);
  // ---------------------------------------------------------------
  // ahb address phase capture
  // ---------------------------------------------------------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       aph;

  assign aph       = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= aph && hwrite && (hsize == 3'h2);
      wr_addr_q <= haddr[7:0];
    end

  // ---------------------------------------------------------------
  // controller registers
  // ---------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [15:0] addr_q, wdata_q, rdata_q;
  logic [2:0]  stat_q, mask_q, ev;
  logic        go_wr, st_wr, busy;
  aiw_pkg::aiw_hstate_t state_q;

  assign go_wr = wr_pend_q && (wr_addr_q == aiw_pkg::H_GO);
  assign st_wr = wr_pend_q && (wr_addr_q == aiw_pkg::H_STAT);
  assign busy  = (state_q == aiw_pkg::AIW_BUSY);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ctrl_q  <= '0;
      addr_q  <= '0;
      wdata_q <= '0;
      mask_q  <= '0;
    end
    else if (wr_pend_q)
      unique case (wr_addr_q)
        aiw_pkg::H_CTRL:  ctrl_q  <= hwdata[2:0];
        aiw_pkg::H_ADDR:  addr_q  <= hwdata[15:0];
        aiw_pkg::H_WDATA: wdata_q <= hwdata[15:0];
        aiw_pkg::H_MASK:  mask_q  <= hwdata[2:0];
        default: ;
      endcase

  // ---------------------------------------------------------------
  // exchange engine
  // ---------------------------------------------------------------
  logic start_ok;
  logic restart_q;

  assign start_ok = go_wr && hwdata[aiw_pkg::GO_START] && ctrl_q[aiw_pkg::HC_TABLES] && !busy;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      state_q    <= aiw_pkg::AIW_IDLE;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
      rdata_q    <= '0;
    end
    else
      unique case (state_q)
        aiw_pkg::AIW_IDLE:
          if (start_ok)
          begin
            state_q    <= aiw_pkg::AIW_BUSY;
            link.req   <= 1'b1;
            link.wr    <= hwdata[aiw_pkg::GO_WRITE];
            link.addr  <= addr_q;
            link.wdata <= wdata_q;
          end
        aiw_pkg::AIW_BUSY:
          if (link.ack)
          begin
            state_q  <= aiw_pkg::AIW_IDLE;
            link.req <= 1'b0;
            if (!link.wr)
              rdata_q <= link.rdata;
          end
      endcase

  // restart pulse applies the unit's parameter area
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      restart_q <= 1'b0;
    else
      restart_q <= go_wr && hwdata[aiw_pkg::GO_RESTART] && !busy;

  assign link.restart = restart_q;
  assign link.standby = ctrl_q[aiw_pkg::HC_STANDBY];
  assign link.fatal   = ctrl_q[aiw_pkg::HC_FATAL];

  // ---------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  always_comb
  begin
    ev = '0;
    ev[aiw_pkg::ST_DONE]    = busy && link.ack;
    ev[aiw_pkg::ST_REFUSED] = go_wr && (hwdata[aiw_pkg::GO_START] || hwdata[aiw_pkg::GO_RESTART]) &&
                              (busy || (hwdata[aiw_pkg::GO_START] && !ctrl_q[aiw_pkg::HC_TABLES]));
    ev[aiw_pkg::ST_RESTART] = restart_q;
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      stat_q <= '0;
    else
      stat_q <= (stat_q & ~(st_wr ? hwdata[2:0] : 3'h0)) | ev;

  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // read data, registered at the address phase
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      hrdata <= '0;
    else if (aph && !hwrite)
      unique case (haddr[7:0])
        aiw_pkg::H_CTRL:  hrdata <= {29'h0, ctrl_q};
        aiw_pkg::H_ADDR:  hrdata <= {16'h0, addr_q};
        aiw_pkg::H_WDATA: hrdata <= {16'h0, wdata_q};
        aiw_pkg::H_RDATA: hrdata <= {16'h0, rdata_q};
        aiw_pkg::H_STAT:  hrdata <= {29'h0, stat_q};
        aiw_pkg::H_MASK:  hrdata <= {29'h0, mask_q};
        aiw_pkg::H_STATE: hrdata <= {31'h0, busy};
        default:          hrdata <= '0;
      endcase

endmodule : aiw_host

// ===== aiw_link_checker.sv
// link protocol checker for the analog i/o word interface
`timescale 1ns/1ps
module aiw_link_checker #(
  parameter int UNIT = 1
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // link signals
  input wire logic        req,
  input wire logic        wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        restart,
  input wire logic        standby,
  input wire logic        fatal,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  localparam logic [15:0] NB = 16'(2000 + 10 * UNIT);
  localparam logic [15:0] MB = 16'(20000 + 100 * UNIT);
  logic mapped;
  assign mapped = (addr >= NB && addr <= NB + 16'd9) || (addr >= MB && addr <= MB + 16'd99);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_ack_after_req: assert property (req && !ack |=> ack)
    else $error("ack did not follow request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed before ack");
  a_req_drops: assert property (ack |=> !req)
    else $error("request not released after ack");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_restart_pulse: assert property (restart |=> !restart)
    else $error("restart longer than one cycle");
  a_unmapped_zero: assert property (req && !ack && !wr && !mapped |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_moves: assert property ($changed(rdata) |-> ack && !wr)
    else $error("read data changed outside read ack");
  c_write: cover property (req && wr && ack);
  c_read: cover property (req && !wr && ack);
  c_restart: cover property (restart);
endmodule : aiw_link_checker

// ===== aiw_tb.sv
// self-checking bench: host and unit ends joined over the word link
`timescale 1ns/1ps
module aiw_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        adj_mode;
  logic [63:0] adc_raw = 64'h0;
  logic [3:0]  disc_raw = 4'h0;
  logic [31:0] dac_word;
  logic [1:0]  dac_live;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  localparam logic [15:0] N = 16'd2010;
  localparam logic [15:0] M = 16'd20100;
  always #10 clk = ~clk;
  aiw_link_if link (.clk(clk));
  aiw_host i_aiw_host (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq(irq), .link(link));
  aiw_device #(.CONV_SLOW_CYC(20)) i_aiw_device (.clk(clk), .nrst(nrst), .link(link), .unit_no(7'h1),
    .adc_raw(adc_raw), .disc_raw(disc_raw), .dac_word(dac_word), .dac_live(dac_live), .adj_mode(adj_mode));
  aiw_link_checker #(.UNIT(1)) i_aiw_link_checker (.clk(clk), .nrst(nrst), .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .restart(link.restart), .standby(link.standby), .fatal(link.fatal),
    .ack(link.ack), .rdata(link.rdata));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // one link transfer or unit restart, finished when the status interrupt shows
  task automatic op(input logic [2:0] go, input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, aiw_pkg::H_ADDR, {16'h0, a});
    bus(1'b1, aiw_pkg::H_WDATA, {16'h0, d});
    bus(1'b1, aiw_pkg::H_GO, {29'h0, go});
    repeat (40) if (irq !== 1'b1) @(posedge clk);
    chk("irq_done", irq, 1'b1);
    bus(1'b1, aiw_pkg::H_STAT, 3'h7);
    bus(1'b0, aiw_pkg::H_RDATA, 1'h0);
  endtask : op
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    op(3'h3, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [15:0] a, input logic [15:0] e);
    op(3'h1, a, 16'h0);
    chk(s, rd[15:0], e);
  endtask : rdc
  task automatic rst_u();
    op(3'h4, 16'h0, 16'h0);
    wr(N, 16'h0003);
  endtask : rst_u
  task automatic tick();
    repeat (45) @(posedge clk);
  endtask : tick
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, aiw_pkg::H_CTRL, 1'h0);
    chk("ctrl_rst", rd, 1'h0);
    bus(1'b1, aiw_pkg::H_MASK, 3'h7);
    bus(1'b1, aiw_pkg::H_CTRL, 1'h1);
    wr(N + 16'd1, 16'h0123);
    rdc("set1", N + 16'd1, 16'h0123);
    wr(16'd2000, 16'h5555);
    rdc("unit0", 16'd2000, 16'h0000);
    rdc("unit2", 16'd2020, 16'h0000);
    rdc("prm_top", M + 16'd100, 16'h0000);
    // out1 and in1 bipolar, the rest 0-10 v
    wr(M + 16'd1, 16'h0577);
    rst_u();
    wr(N + 16'd1, 16'h8000);
    wr(N + 16'd2, 16'h7fff);
    adc_raw <= {16'h0100, 16'h0fa0, 16'h0000, 16'hf768};
    disc_raw <= 4'ha;
    tick();
    chk("out1_min", dac_word[15:0], 16'hf768);
    chk("out2_max", dac_word[31:16], 16'h0fa0);
    chk("live", dac_live, 2'h3);
    for (int i = 0; i < 4; i++) rdc("conv", N + 16'd5 + 16'(i), adc_raw[16*i +: 16]);
    op(3'h1, N + 16'd9, 16'h0);
    chk("disc", rd[7:4], 4'ha);
    wr(N + 16'd1, 16'h0898);
    tick();
    chk("bip_top", dac_word[15:0], 16'h0898);
    wr(M + 16'd1, 16'h0574);
    wr(N + 16'd1, 16'h1000);
    tick();
    chk("no_apply", dac_word[15:0], 16'h0898);
    wr(M + 16'd2, 16'h0008);
    rst_u();
    wr(N + 16'd1, 16'h1000);
    tick();
    chk("applied", dac_word[15:0], 16'h0fa0);
    wr(N, 16'h0000);
    tick();
    chk("hold_clr", dac_word, 32'h0fa0_0000);
    chk("stopped", dac_live, 2'h0);
    wr(N, 16'h0003);
    bus(1'b1, aiw_pkg::H_CTRL, 2'h3);
    tick();
    chk("standby", dac_live, 2'h0);
    bus(1'b1, aiw_pkg::H_CTRL, 1'h1);
    wr(M, 16'h0001);
    chk("adj_early", adj_mode, 1'b0);
    rst_u();
    chk("adj_on", adj_mode, 1'b1);
    op(3'h1, N + 16'd9, 16'h0);
    chk("adj_flag", rd[13], 1'b1);
    wr(M, 16'h0000);
    rst_u();
    chk("adj_off", adj_mode, 1'b0);
    wr(M + 16'd18, 16'h0001);
    rst_u();
    wr(N + 16'd2, 16'h7fff);
    tick();
    chk("fast_max", dac_word[31:16], 16'h1f40);
    wr(N, 16'h0013);
    adc_raw[15:0] <= 16'h0100;
    tick();
    adc_raw[15:0] <= 16'h0000;
    tick();
    rdc("peak", N + 16'd5, 16'h0100);
    bus(1'b1, aiw_pkg::H_CTRL, 3'h5);
    tick();
    chk("fatal_live", dac_live, 2'h0);
    chk("fatal_hold", dac_word, 32'h1f40_0000);
    bus(1'b1, aiw_pkg::H_CTRL, 1'h1);
    bus(1'b1, aiw_pkg::H_MASK, 1'h0);
    bus(1'b1, aiw_pkg::H_ADDR, {16'h0, N});
    bus(1'b1, aiw_pkg::H_GO, 1'h1);
    repeat (10) @(posedge clk);
    chk("irq_masked", irq, 1'b0);
    bus(1'b0, aiw_pkg::H_STAT, 1'h0);
    chk("done_bit", rd[0], 1'b1);
    bus(1'b1, aiw_pkg::H_MASK, 3'h7);
    repeat (2) @(posedge clk);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, aiw_pkg::H_STAT, 3'h7);
    repeat (2) @(posedge clk);
    chk("irq_clr", irq, 1'b0);
    bus(1'b1, aiw_pkg::H_CTRL, 1'h0);
    bus(1'b1, aiw_pkg::H_GO, 1'h1);
    bus(1'b0, aiw_pkg::H_STAT, 1'h0);
    chk("refused", rd[2:0], 3'h2);
    chk("hresp", hresp, 1'b0);
    chk("hready", hreadyout, 1'b1);
    complete_run();
  end
endmodule : aiw_tb
